// >>> asbo_map.svh
// register offsets, field positions, reset values and command codes of the axis-select and bit-output block
`ifndef ASBO_MAP_SVH
`define ASBO_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ASBO_OFF_CMD       8'h00
`define ASBO_OFF_RESP      8'h04
`define ASBO_OFF_STATUS    8'h08
`define ASBO_OFF_AXCFG     8'h0C
`define ASBO_OFF_DIR       8'h10
`define ASBO_OFF_GPIO      8'h14
`define ASBO_OFF_BACKLASH  8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ASBO_CMD_OP_LSB    0
`define ASBO_CMD_ARG_LSB   8
`define ASBO_ST_SAVE_BIT   7
`define ASBO_ST_PEND_BIT   8
`define ASBO_ST_RESP_BIT   9
`define ASBO_ST_DISC_BIT   10

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define ASBO_GPO_RST       8'hFF
`define ASBO_DIR_RST       8'hFF
`define ASBO_BIPOLAR_RST   4'hF
`define ASBO_SERVO_RST     4'h0
`define ASBO_BL_MAX        8'h32
`define ASBO_BL_MIN        8'hCE
`define ASBO_BIT_MAX       8'h07

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define ASBO_OP_SAVE       8'h01
`define ASBO_OP_QMODE      8'h02
`define ASBO_OP_SEL_X      8'h03
`define ASBO_OP_SEL_Y      8'h04
`define ASBO_OP_SEL_Z      8'h05
`define ASBO_OP_SEL_T      8'h06
`define ASBO_OP_SET_BL     8'h07
`define ASBO_OP_QBL        8'h08
`define ASBO_OP_BIT_HIGH   8'h09
`define ASBO_OP_BIT_LOW    8'h0A
`define ASBO_OP_BIPOLAR    8'h0B
`define ASBO_OP_SEL_ALL    8'h0C
`define ASBO_OP_SEL_MULTI  8'h0D
`define ASBO_OP_CD_ENTER   8'h0E
`define ASBO_OP_CD_EXIT    8'h0F

`endif

// >>> asbo_pkg.sv
// types shared by the axis-select and bit-output block
package asbo_pkg;

  typedef enum logic [6:0] {
    ASBO_MODE_X     = 7'b000_0001,
    ASBO_MODE_Y     = 7'b000_0010,
    ASBO_MODE_Z     = 7'b000_0100,
    ASBO_MODE_T     = 7'b000_1000,
    ASBO_MODE_ALL   = 7'b001_0000,
    ASBO_MODE_MULTI = 7'b010_0000,
    ASBO_MODE_CD    = 7'b100_0000
  } asbo_mode_t;

  typedef enum logic [1:0] {
    ASBO_SV_IDLE = 2'b01,
    ASBO_SV_BUSY = 2'b10
  } asbo_save_st_t;

  typedef struct packed {
    asbo_mode_t       mode;
    logic [3:0][7:0]  backlash;
    logic [3:0]       bipolar;
    logic [3:0]       servo;
    logic [7:0]       gpo;
    logic [7:0]       dir;
    logic             pend;
    logic             pend_low;
    logic [2:0]       pend_bit;
    logic [3:0]       pend_mask;
    logic [7:0]       resp;
    logic             resp_valid;
    logic             discard;
    logic             rd_ack;
    logic [31:0]      rdata;
    logic             save_go;
  } asbo_core_t;

  function automatic logic asbo_single(input asbo_mode_t m);
    asbo_single = (m == ASBO_MODE_X) || (m == ASBO_MODE_Y) || (m == ASBO_MODE_Z) || (m == ASBO_MODE_T);
  endfunction : asbo_single

endpackage : asbo_pkg

// >>> asbo_cmd_class.sv
// command classifier: known code, valid in the current mode, queued or immediate
`timescale 1ns/1ns
`include "asbo_map.svh"
module asbo_cmd_class
  import asbo_pkg::*;
(
  input  wire logic [7:0] op,
  input  wire asbo_mode_t mode,
  output logic            known,
  output logic            valid,
  output logic            queued
);
  logic single;
  logic multi;

  always_comb begin
    single = asbo_single(mode);
    multi  = (mode == ASBO_MODE_ALL) || (mode == ASBO_MODE_MULTI);
    known  = 1'b1;
    valid  = 1'b0;
    queued = 1'b0;
    case (op)
      `ASBO_OP_SAVE, `ASBO_OP_SEL_X, `ASBO_OP_SEL_Y, `ASBO_OP_SEL_Z, `ASBO_OP_SEL_T,
      `ASBO_OP_SEL_ALL, `ASBO_OP_SEL_MULTI: valid = single | multi;
      `ASBO_OP_QMODE:                       valid = 1'b1;
      `ASBO_OP_SET_BL, `ASBO_OP_QBL, `ASBO_OP_BIPOLAR: valid = single;
      `ASBO_OP_BIT_HIGH, `ASBO_OP_BIT_LOW: begin
        valid  = 1'b1;
        queued = 1'b1;
      end
      `ASBO_OP_CD_ENTER:                    valid = multi;
      `ASBO_OP_CD_EXIT:                     valid = (mode == ASBO_MODE_CD);
      default:                              known = 1'b0;
    endcase
  end
endmodule : asbo_cmd_class

// >>> asbo_flash_saver.sv
// snapshots the live parameter set and writes it word by word to the flash port
`timescale 1ns/1ns
module asbo_flash_saver
  import asbo_pkg::*;
#(
  parameter int NUM_WORDS = 5,
  parameter int AW        = 8
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   ce,
  input  wire logic                   start,
  input  wire logic [NUM_WORDS*8-1:0] params,
  output logic                        busy,
  output logic                        flash_req,
  output logic [AW-1:0]               flash_addr,
  output logic [7:0]                  flash_data,
  input  wire logic                   flash_ack
);
  typedef struct packed {
    asbo_save_st_t          st;
    logic [NUM_WORDS*8-1:0] snap;
    logic [AW-1:0]          idx;
    logic [7:0]             data;
  } asbo_saver_t;

  asbo_saver_t s_q;
  asbo_saver_t s_d;

  always_comb begin
    s_d = s_q;
    case (s_q.st)
      ASBO_SV_IDLE: begin
        if (start) begin
          // snapshot first so later parameter edits cannot tear the saved set
          s_d.snap = params;
          s_d.idx  = '0;
          s_d.data = params[7:0];
          s_d.st   = ASBO_SV_BUSY;
        end
      end
      ASBO_SV_BUSY: begin
        if (flash_ack) begin
          if (s_q.idx == AW'(NUM_WORDS - 1)) begin
            s_d.st = ASBO_SV_IDLE;
          end else begin
            s_d.idx  = s_q.idx + AW'(1);
            s_d.data = s_q.snap[8*(32'(s_q.idx)+1) +: 8];
          end
        end
      end
      default: s_d.st = ASBO_SV_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '{st: ASBO_SV_IDLE, default: '0};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign busy       = (s_q.st == ASBO_SV_BUSY);
  assign flash_req  = busy & ce;
  assign flash_addr = s_q.idx;
  assign flash_data = s_q.data;
endmodule : asbo_flash_saver

// >>> asbo_top.sv
// command interpreter for axis selection, backlash, bipolar output and general-purpose output bits
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
`include "asbo_map.svh"
module asbo_top
  import asbo_pkg::*;
#(
  parameter int FLASH_AW = 8
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                ce,
  input  wire logic [7:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic [3:0]          axis_busy,
  input  wire logic [7:0]          gpio_in,
  output logic [7:0]               gpo_out,
  output logic [7:0]               gpio_dir,
  output logic [31:0]              backlash_out,
  output logic [3:0]               bipolar_out,
  output logic [6:0]               mode_out,
  output logic                     flash_req,
  output logic [FLASH_AW-1:0]      flash_addr,
  output logic [7:0]               flash_data,
  input  wire logic                flash_ack
);

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  localparam int NUM_PARAM_WORDS = 5;

  localparam asbo_core_t CORE_RST = '{
    mode:     ASBO_MODE_X,
    bipolar:  `ASBO_BIPOLAR_RST,
    servo:    `ASBO_SERVO_RST,
    gpo:      `ASBO_GPO_RST,
    dir:      `ASBO_DIR_RST,
    default:  '0
  };

  asbo_core_t s_q;
  asbo_core_t s_d;

  logic [7:0]  cmd_op;
  logic [7:0]  cmd_arg;
  logic        cmd_known;
  logic        cmd_valid;
  logic        cmd_queued;
  logic        cmd_sel;
  logic        cmd_wr;
  logic        save_busy;
  logic [1:0]  ax;
  logic        bl_ok;
  logic        pend_free;
  logic [7:0]  gpio_view;
  logic [NUM_PARAM_WORDS*8-1:0] param_set;

  assign cmd_op  = avs_writedata[`ASBO_CMD_OP_LSB +: 8];
  assign cmd_arg = avs_writedata[`ASBO_CMD_ARG_LSB +: 8];
  assign cmd_sel = (avs_address == `ASBO_OFF_CMD) && (avs_byteenable[1:0] == 2'b11);

  asbo_cmd_class u_class (
    .op     (cmd_op),
    .mode   (s_q.mode),
    .known  (cmd_known),
    .valid  (cmd_valid),
    .queued (cmd_queued)
  );

  function automatic logic [1:0] axis_of(input asbo_mode_t m);
    case (m)
      ASBO_MODE_Y: axis_of = 2'd1;
      ASBO_MODE_Z: axis_of = 2'd2;
      ASBO_MODE_T: axis_of = 2'd3;
      default:     axis_of = 2'd0;
    endcase
  endfunction : axis_of

  function automatic logic [7:0] apply_bit(input logic [7:0] gpo, input logic [7:0] dir,
                                           input logic [2:0] idx, input logic low);
    logic [7:0] r;
    r = gpo;
    if (dir[idx]) begin
      r[idx] = ~low;
    end
    apply_bit = r;
  endfunction : apply_bit

  assign ax = axis_of(s_q.mode);

  // backlash range depends on the axis motor type
  always_comb begin
    if (s_q.servo[ax]) begin
      bl_ok = ($signed(cmd_arg) >= $signed(`ASBO_BL_MIN)) && ($signed(cmd_arg) <= $signed(`ASBO_BL_MAX));
    end else begin
      bl_ok = ($signed(cmd_arg) >= $signed(8'h00)) && ($signed(cmd_arg) <= $signed(`ASBO_BL_MAX));
    end
  end

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // a queued command can only wait in a single slot, so a second one stalls the bus
  // instead of being dropped; a save also stalls while the previous save is still writing
  always_comb begin
    avs_waitrequest = 1'b0;
    if (!ce) begin
      avs_waitrequest = 1'b1;
    end else if (avs_read && !s_q.rd_ack) begin
      avs_waitrequest = 1'b1;
    end else if (avs_write && cmd_sel && cmd_valid && cmd_queued && s_q.pend) begin
      avs_waitrequest = 1'b1;
    end else if (avs_write && cmd_sel && cmd_valid && cmd_op == `ASBO_OP_SAVE && (save_busy || s_q.save_go)) begin
      avs_waitrequest = 1'b1;
    end
  end

  assign cmd_wr    = avs_write && !avs_waitrequest && cmd_sel;
  assign pend_free = s_q.pend && ((axis_busy & s_q.pend_mask) == 4'h0);
  assign gpio_view = (s_q.gpo & s_q.dir) | (gpio_in & ~s_q.dir);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.save_go = 1'b0;

    // read path: one wait cycle, data registered
    if (avs_read && !s_q.rd_ack) begin
      s_d.rd_ack = 1'b1;
      case (avs_address)
        `ASBO_OFF_RESP:     s_d.rdata = {23'h00_0000, s_q.resp_valid, s_q.resp};
        `ASBO_OFF_STATUS: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rdata[6:0] = s_q.mode;
          s_d.rdata[`ASBO_ST_SAVE_BIT] = save_busy | s_q.save_go;
          s_d.rdata[`ASBO_ST_PEND_BIT] = s_q.pend;
          s_d.rdata[`ASBO_ST_RESP_BIT] = s_q.resp_valid;
          s_d.rdata[`ASBO_ST_DISC_BIT] = s_q.discard;
        end
        `ASBO_OFF_AXCFG:    s_d.rdata = {24'h00_0000, s_q.bipolar, s_q.servo};
        `ASBO_OFF_DIR:      s_d.rdata = {24'h00_0000, s_q.dir};
        `ASBO_OFF_GPIO:     s_d.rdata = {24'h00_0000, gpio_view};
        `ASBO_OFF_BACKLASH: s_d.rdata = s_q.backlash;
        default:            s_d.rdata = 32'h0000_0000;
      endcase
    end else begin
      s_d.rd_ack = 1'b0;
    end

    // clears come before sets so a same-cycle event wins
    if (avs_read && s_q.rd_ack && avs_address == `ASBO_OFF_RESP) begin
      s_d.resp_valid = 1'b0;
    end
    if (avs_write && !avs_waitrequest) begin
      case (avs_address)
        `ASBO_OFF_STATUS: begin
          if (avs_byteenable[1] && avs_writedata[`ASBO_ST_DISC_BIT]) begin
            s_d.discard = 1'b0;
          end
        end
        `ASBO_OFF_AXCFG: begin
          if (avs_byteenable[0]) begin
            s_d.servo   = avs_writedata[3:0];
            s_d.bipolar = avs_writedata[7:4];
          end
        end
        `ASBO_OFF_DIR: begin
          if (avs_byteenable[0]) begin
            s_d.dir = avs_writedata[7:0];
          end
        end
        default: begin
        end
      endcase
    end

    // queued bit command leaves the slot once its axes are idle
    if (pend_free) begin
      s_d.gpo  = apply_bit(s_q.gpo, s_q.dir, s_q.pend_bit, s_q.pend_low);
      s_d.pend = 1'b0;
    end

    // command execution
    if (cmd_wr) begin
      if (!cmd_known || !cmd_valid) begin
        s_d.discard = 1'b1;
      end else begin
        case (cmd_op)
          `ASBO_OP_SAVE: s_d.save_go = 1'b1;
          `ASBO_OP_QMODE: begin
            s_d.resp       = {1'b0, s_q.mode};
            s_d.resp_valid = 1'b1;
          end
          `ASBO_OP_SEL_X:     s_d.mode = ASBO_MODE_X;
          `ASBO_OP_SEL_Y:     s_d.mode = ASBO_MODE_Y;
          `ASBO_OP_SEL_Z:     s_d.mode = ASBO_MODE_Z;
          `ASBO_OP_SEL_T:     s_d.mode = ASBO_MODE_T;
          `ASBO_OP_SEL_ALL:   s_d.mode = ASBO_MODE_ALL;
          `ASBO_OP_SEL_MULTI: s_d.mode = ASBO_MODE_MULTI;
          `ASBO_OP_CD_ENTER:  s_d.mode = ASBO_MODE_CD;
          `ASBO_OP_CD_EXIT:   s_d.mode = ASBO_MODE_ALL;
          `ASBO_OP_SET_BL: begin
            if (bl_ok) begin
              s_d.backlash[ax] = cmd_arg;
            end else begin
              s_d.discard = 1'b1;
            end
          end
          `ASBO_OP_QBL: begin
            s_d.resp       = s_q.backlash[ax];
            s_d.resp_valid = 1'b1;
          end
          `ASBO_OP_BIPOLAR: s_d.bipolar[ax] = 1'b1;
          `ASBO_OP_BIT_HIGH, `ASBO_OP_BIT_LOW: begin
            if (cmd_arg > `ASBO_BIT_MAX) begin
              s_d.discard = 1'b1;
            end else begin
              s_d.pend      = 1'b1;
              s_d.pend_low  = (cmd_op == `ASBO_OP_BIT_LOW);
              s_d.pend_bit  = cmd_arg[2:0];
              s_d.pend_mask = asbo_single(s_q.mode) ? (4'h1 << ax) : 4'hF;
            end
          end
          default: s_d.discard = 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= CORE_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // flash save
  // ----------------------------------------------------------------
  assign param_set = {4'h0, s_q.bipolar, s_q.backlash};

  asbo_flash_saver #(
    .NUM_WORDS (NUM_PARAM_WORDS),
    .AW        (FLASH_AW)
  ) u_saver (
    .clk        (clk),
    .reset      (reset),
    .ce         (ce),
    .start      (s_q.save_go),
    .params     (param_set),
    .busy       (save_busy),
    .flash_req  (flash_req),
    .flash_addr (flash_addr),
    .flash_data (flash_data),
    .flash_ack  (flash_ack)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata = s_q.rdata;
  assign gpo_out      = s_q.gpo;
  assign gpio_dir     = s_q.dir;
  assign backlash_out = s_q.backlash;
  assign bipolar_out  = s_q.bipolar;
  assign mode_out     = s_q.mode;

endmodule : asbo_top

// >>> asbo_flash_model.sv
// flash device model answering the save port of the block
`timescale 1ns/1ns
module asbo_flash_model
#(
  parameter int FLASH_AW = 8
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic [3:0]          lat,
  input  wire logic                flash_req,
  input  wire logic [FLASH_AW-1:0] flash_addr,
  input  wire logic [7:0]          flash_data,
  output logic                     flash_ack,
  output logic [4:0][7:0]          mem,
  output logic [3:0]               words
);
  logic [3:0] cnt_q;

  // a programmable latency lets the block see slow writes
  always @(posedge clk) begin
    flash_ack <= 1'b0;
    if (reset) begin
      cnt_q <= 4'h0;
      words <= 4'h0;
    end else if (flash_req && !flash_ack) begin
      if (cnt_q >= lat) begin
        flash_ack <= 1'b1;
        mem[flash_addr[2:0]] <= flash_data;
        words <= words + 4'h1;
        cnt_q <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule : asbo_flash_model

// >>> asbo_top_properties.sv
// concurrent checks on the ports of the axis-select and bit-output block
`timescale 1ns/1ns
module asbo_top_checker
#(
  parameter int FLASH_AW = 8
) (
  input wire logic                clk,
  input wire logic                reset,
  input wire logic                ce,
  input wire logic [7:0]          avs_address,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [31:0]         avs_writedata,
  input wire logic [3:0]          avs_byteenable,
  input wire logic                avs_waitrequest,
  input wire logic [3:0]          axis_busy,
  input wire logic [7:0]          gpo_out,
  input wire logic [7:0]          gpio_dir,
  input wire logic [31:0]         backlash_out,
  input wire logic [3:0]          bipolar_out,
  input wire logic [6:0]          mode_out,
  input wire logic                flash_req,
  input wire logic [FLASH_AW-1:0] flash_addr,
  input wire logic [7:0]          flash_data,
  input wire logic                flash_ack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic wr_ok;
  logic single;
  assign wr_ok  = ce && avs_write && !avs_waitrequest && avs_address == 8'h00 && avs_byteenable[1:0] == 2'b11;
  assign single = mode_out[3:0] != 4'h0;

  // bit command accepted with all axes idle across the apply cycle
  sequence s_bitcmd(logic [7:0] op);
    wr_ok && avs_writedata[7:0] == op && avs_writedata[15:11] == 5'h00 && gpio_dir[avs_writedata[10:8]] &&
      axis_busy == 4'h0 ##1 ce && axis_busy == 4'h0;
  endsequence

  chk_read_wait: assert property (ce && avs_read && avs_waitrequest ##1 ce && avs_read |-> !avs_waitrequest)
    else $error("read not answered after one wait state");
  chk_reset_vals: assert property ($fell(reset) && $past(ce) |-> gpo_out == 8'hFF && gpio_dir == 8'hFF &&
    mode_out == 7'h01 && bipolar_out == 4'hF && backlash_out == 32'h0000_0000) else $error("bad reset state");
  chk_mode_onehot: assert property ($onehot(mode_out)) else $error("mode not one-hot");
  chk_select_axis: assert property (wr_ok && mode_out != 7'h40 && avs_writedata[7:0] == 8'h04 |=> mode_out == 7'h02)
    else $error("axis select ignored");
  chk_cd_refuse: assert property (wr_ok && mode_out == 7'h40 && avs_writedata[7:0] inside {[8'h03:8'h06]}
    |=> mode_out == 7'h40) else $error("select taken in contour mode");
  chk_bl_range: assert property (wr_ok && single && avs_writedata[7:0] == 8'h07 &&
    avs_writedata[15:8] inside {[8'h33:8'h7F]} |=> $stable(backlash_out)) else $error("backlash out of range taken");
  chk_bit_low: assert property (s_bitcmd(8'h0A) |=> gpo_out[$past(avs_writedata[10:8], 2)] == 1'b0)
    else $error("output bit not driven low");
  chk_bit_high: assert property (s_bitcmd(8'h09) |=> gpo_out[$past(avs_writedata[10:8], 2)] == 1'b1)
    else $error("output bit not driven high");
  chk_input_kept: assert property (wr_ok && avs_writedata[7:0] inside {8'h09, 8'h0A} &&
    avs_writedata[15:11] == 5'h00 && !gpio_dir[avs_writedata[10:8]] |=> $stable(gpo_out)[*2])
    else $error("input line altered");
  chk_flash_hold: assert property (ce && flash_req && !flash_ack |=> flash_req && $stable(flash_addr) &&
    $stable(flash_data)) else $error("flash word dropped before ack");
  chk_save_start: assert property (wr_ok && mode_out != 7'h40 && avs_writedata[7:0] == 8'h01 && !flash_req
    |-> ##[1:2] flash_req && flash_addr == '0 && flash_data == backlash_out[7:0]) else $error("save did not start");
endmodule : asbo_top_checker

bind asbo_top asbo_top_checker #(.FLASH_AW(FLASH_AW)) asbo_top_checker_i (.*);

// >>> tb.sv
// self-checking bench for the axis-select and bit-output block
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic [15:0] cmd;
    logic [7:0]  addr;
    logic [31:0] mask;
    logic [31:0] exp;
  } asbo_row_t;
  logic            clk = 1'b0;
  logic            reset = 1'b1;
  logic            ce = 1'b1;
  logic [7:0]      avs_address = 8'h00;
  logic            avs_read = 1'b0;
  logic            avs_write = 1'b0;
  logic [31:0]     avs_writedata = 32'h0000_0000;
  logic [3:0]      avs_byteenable = 4'hF;
  logic [31:0]     avs_readdata;
  logic            avs_waitrequest;
  logic [3:0]      axis_busy = 4'h0;
  logic [7:0]      gpio_in = 8'h5A;
  logic [7:0]      gpo_out;
  logic [7:0]      gpio_dir;
  logic [31:0]     backlash_out;
  logic [3:0]      bipolar_out;
  logic [6:0]      mode_out;
  logic            flash_req;
  logic [7:0]      flash_addr;
  logic [7:0]      flash_data;
  logic            flash_ack;
  logic [3:0]      lat = 4'h2;
  logic [4:0][7:0] mem;
  logic [3:0]      words;
  logic [31:0]     rd;
  int              miscompares = 0;
  int              checks_done = 0;
  // command word, register read back, mask, expected value
  asbo_row_t rows [15] = '{
    '{16'h0004, 8'h08, 32'h7F, 32'h02}, '{16'h1907, 8'h18, 32'hFF00, 32'h1900},
    '{16'h0008, 8'h04, 32'h1FF, 32'h119}, '{16'h0005, 8'h08, 32'h7F, 32'h04},
    '{16'h3307, 8'h18, 32'hFF_0000, 32'h0}, '{16'h0006, 8'h08, 32'h7F, 32'h08},
    '{16'h000C, 8'h08, 32'h7F, 32'h10}, '{16'h0007, 8'h18, 32'hFFFF_FFFF, 32'h1900},
    '{16'h000E, 8'h08, 32'h7F, 32'h40}, '{16'h0004, 8'h08, 32'h7F, 32'h40},
    '{16'h000F, 8'h08, 32'h7F, 32'h10}, '{16'h000D, 8'h08, 32'h7F, 32'h20},
    '{16'h0002, 8'h04, 32'h100, 32'h100}, '{16'h0003, 8'h08, 32'h7F, 32'h01},
    '{16'hCE07, 8'h18, 32'hFF, 32'h0}
  };

  always #25 clk = ~clk;

  asbo_top asbo_top_i (.*);
  asbo_flash_model asbo_flash_model_i (.*);

  // ----
  // shared tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  // one Avalon transfer; the idle edge after it keeps strobes from being set twice in a step
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    // waitrequest is looked at mid-cycle, where it has settled to the value the next rising edge samples
    do begin
      @(negedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 300);
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      report_and_stop();
    end
    rd = avs_readdata;
    @(posedge clk);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic cmd(input logic [15:0] w);
    bus(1'b1, 8'h00, {16'h0000, w}, 4'hF);
  endtask : cmd

  // ----
  // main sequence
  // ----
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check({gpo_out, gpio_dir, 1'b0, mode_out, 4'h0, bipolar_out}, 32'hFFFF_010F);
    check(backlash_out, 32'h0000_0000);
    bus(1'b1, 8'h40, 32'hFFFF_FFFF, 4'hF);
    bus(1'b0, 8'h40, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_0000);
    $display("test reset done");
    foreach (rows[i]) begin
      cmd(rows[i].cmd);
      bus(1'b0, rows[i].addr, 32'h0000_0000, 4'hF);
      check(rd & rows[i].mask, rows[i].exp);
    end
    bus(1'b0, 8'h08, 32'h0000_0000, 4'hF);
    check(rd[10], 1'b1);
    bus(1'b1, 8'h08, 32'h0000_0400, 4'h2);
    bus(1'b0, 8'h08, 32'h0000_0000, 4'hF);
    check(rd[10], 1'b0);
    $display("test rows done");
    for (int i = 0; i < 8; i++) begin
      cmd({5'h00, 3'(i), 8'h0A});
      @(posedge clk);
      check(gpo_out, 8'(~(8'h01 << i)));
      cmd({5'h00, 3'(i), 8'h09});
      @(posedge clk);
      check(gpo_out, 8'hFF);
    end
    cmd(16'h080A);
    @(posedge clk);
    check(gpo_out, 8'hFF);
    axis_busy <= 4'h1;
    fork
      begin
        cmd(16'h040A);
        cmd(16'h050A);
      end
      begin
        repeat (6) @(posedge clk);
        check(gpo_out, 8'hFF);
        axis_busy <= 4'h0;
      end
    join
    @(posedge clk);
    check(gpo_out, 8'hCF);
    cmd(16'h0409);
    cmd(16'h0509);
    bus(1'b1, 8'h10, 32'h0000_00FE, 4'h1);
    cmd(16'h000A);
    repeat (2) @(posedge clk);
    bus(1'b0, 8'h14, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_00FE);
    bus(1'b1, 8'h10, 32'h0000_00FF, 4'h1);
    $display("test bits done");
    bus(1'b1, 8'h0C, 32'h0000_0001, 4'h1);
    check(bipolar_out, 4'h0);
    cmd(16'h000B);
    check(bipolar_out, 4'h1);
    cmd(16'hCE07);
    check(backlash_out[7:0], 8'hCE);
    cmd(16'hCD07);
    check(backlash_out[7:0], 8'hCE);
    lat <= 4'h3;
    cmd(16'h0001);
    for (int n = 0; n < 100 && words != 4'h5; n++)
      @(posedge clk);
    check(words, 4'h5);
    check(mem[4], 8'h01);
    check(mem[3:0], 32'h0000_19CE);
    // clock enable low must hold the command off and freeze the mode
    ce <= 1'b0;
    fork
      cmd(16'h0005);
      begin
        repeat (4) @(posedge clk);
        check(mode_out, 7'h01);
        ce <= 1'b1;
      end
    join
    check(mode_out, 7'h04);
    $display("test save done");
    report_and_stop();
  end
endmodule : tb
